/* hdl/spg_defs.vh */
// Purpose: Constants for the strobe pattern GPIO pin block.
// Assumes: Field positions in Verilog bit order; bit n of the
//          register map (bit 0 = MSB) sits at Verilog bit 31-n.
// Notes:   Definitions only.
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH

`define SPG_ADDR_W          16
`define SPG_OFF_PAT_CTRL    16'h110c
`define SPG_OFF_PIN_CTRL    16'h1110
`define SPG_OFF_PIN_TIMING  16'h1114
`define SPG_OFF_PAT_MASK    16'h1118

`define SPG_PRESENCE_BIT    31
`define SPG_PERIOD_HI       12
`define SPG_PERIOD_LO       8
`define SPG_COUNT_HI        3
`define SPG_COUNT_LO        0
`define SPG_MODE_HI         19
`define SPG_MODE_LO         16
`define SPG_DATA_HI         15
`define SPG_DATA_LO         0
`define SPG_LEVEL_BIT       0
`define SPG_DELAY_HI        31
`define SPG_DELAY_LO        16
`define SPG_DUR_HI          15
`define SPG_DUR_LO          0
`define SPG_MASK_HI         15
`define SPG_MASK_LO         0

`define SPG_MODE_INPUT      4'h0
`define SPG_MODE_OUTPUT     4'h1
`define SPG_MODE_TRIGGER    4'h2
`define SPG_MODE_STROBE     4'h3
`define SPG_MODE_PWM        4'h4
`define SPG_MODE_OUTPUT_ALT 4'h8

`define SPG_RST_PERIOD      5'h01
`define SPG_RST_MODE        4'h0
`define SPG_RST_DATA        16'h0000
`define SPG_RST_TIMING      32'h0000_0000
`define SPG_RST_MASK        16'hffff

`endif

/* hdl/spg_gpio_pin.v */
// Purpose: One camera GPIO pin with strobe pattern counter.
// Assumes: tick is a one-cycle pulse at the timing-clock rate;
//          all inputs synchronous to clk.
// Notes:   Registers reached by a simple read/write port.
`timescale 1ns/1ps
`default_nettype none
`include "spg_defs.vh"

module spg_gpio_pin (
   input  wire                   clk,
   input  wire                   resetn,
   input  wire                   tick,
   input  wire                   integ_start,
   input  wire                   strobe_ref_trig,
   input  wire [`SPG_ADDR_W-1:0] reg_addr,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   input  wire [31:0]            reg_wdata,
   output reg  [31:0]            reg_rdata,
   input  wire                   pin_in,
   output reg                    pin_out,
   output reg                    pin_oe,
   output reg                    trig_event
);

   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_DELAY = 3'b010;
   localparam [2:0] ST_PULSE = 3'b100;

   reg        rst_meta;
   reg        rst_sync_n;
   reg [4:0]  period;
   reg [3:0]  count;
   reg [3:0]  mode;
   reg [15:0] pin_data;
   reg [31:0] timing;
   reg [15:0] mask;
   reg        pin_q;
   reg [2:0]  st;
   reg [15:0] tcnt;
   reg        pwm_high;
   reg [15:0] pwm_cnt;

   wire [15:0] delay_t = timing[`SPG_DELAY_HI:`SPG_DELAY_LO];
   wire [15:0] dur_t   = timing[`SPG_DUR_HI:`SPG_DUR_LO];
   wire        pol     = pin_data[`SPG_LEVEL_BIT];

   // Mode decode; unlisted codes leave the pad undriven
   wire m_in   = (mode == `SPG_MODE_INPUT);
   wire m_trig = (mode == `SPG_MODE_TRIGGER);
   wire m_str  = (mode == `SPG_MODE_STROBE);
   wire m_pwm  = (mode == `SPG_MODE_PWM);
   wire m_out  = (mode == `SPG_MODE_OUTPUT) || (mode == `SPG_MODE_OUTPUT_ALT);

   wire trig_hit = m_trig && (pol ? (pin_in && !pin_q) : (!pin_in && pin_q));

   wire strobe_ref = strobe_ref_trig ? trig_hit : integ_start;

   // Wrap at period minus one, at 15 for periods above 16; zero period treated as one
   wire [4:0] last_cnt = (period == 5'h00) ? 5'h00 : period - 5'h01;
   wire [3:0] next_count = ({1'b0, count} >= last_cnt) ? 4'h0 : count + 4'h1;

   // Mask bit 16 at Verilog bit 15
   wire [15:0] mask_by_count;
   genvar      gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_mask
         assign mask_by_count[gi] = mask[15 - gi];
      end
   endgenerate

   wire        pat_ok = mask_by_count[count];

   // Exact address match; other addresses ignored
   wire wr_pat  = reg_wr && (reg_addr == `SPG_OFF_PAT_CTRL);
   wire wr_ctrl = reg_wr && (reg_addr == `SPG_OFF_PIN_CTRL);
   wire wr_tim  = reg_wr && (reg_addr == `SPG_OFF_PIN_TIMING);
   wire wr_mask = reg_wr && (reg_addr == `SPG_OFF_PAT_MASK);

   // Reset asserts at once, releases on a clock edge
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Pattern period; count bits of the same word are read-only
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         period <= `SPG_RST_PERIOD;
      end else begin
         if (wr_pat) begin
            period <= reg_wdata[`SPG_PERIOD_HI:`SPG_PERIOD_LO];
         end
      end
   end

   // Pin function and its data field
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mode     <= `SPG_RST_MODE;
         pin_data <= `SPG_RST_DATA;
      end else begin
         if (wr_ctrl) begin
            mode     <= reg_wdata[`SPG_MODE_HI:`SPG_MODE_LO];
            pin_data <= reg_wdata[`SPG_DATA_HI:`SPG_DATA_LO];
         end
      end
   end

   // Delay and duration, both halves writable
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timing <= `SPG_RST_TIMING;
      end else begin
         if (wr_tim) begin
            timing <= reg_wdata;
         end
      end
   end

   // Pattern mask; presence and reserved bits dropped
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mask <= `SPG_RST_MASK;
      end else begin
         if (wr_mask) begin
            mask <= reg_wdata[`SPG_MASK_HI:`SPG_MASK_LO];
         end
      end
   end

   // Pattern counter
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count <= 4'h0;
      end else begin
         if (strobe_ref) begin
            count <= next_count;
         end
      end
   end

   // Pwm phases; high lasts duration, low lasts delay, in ticks; a zero field and the first low phase last one tick
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwm_high <= 1'b0;
         pwm_cnt  <= 16'h0000;
      end else if (!m_pwm) begin
         pwm_high <= 1'b0;
         pwm_cnt  <= 16'h0000;
      end else if (tick) begin
         if (pwm_cnt <= 16'h0001) begin
            pwm_high <= !pwm_high;
            pwm_cnt  <= pwm_high ? delay_t : dur_t;
         end else begin
            pwm_cnt <= pwm_cnt - 16'h0001;
         end
      end
   end

   // Strobe timing
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st   <= ST_IDLE;
         tcnt <= 16'h0000;
      end else if (m_pwm) begin
         st <= ST_IDLE;
      end else begin
         case (st)
            ST_IDLE: begin
               // References during a strobe in flight are ignored
               // Gate by pattern mask
               if (m_str && strobe_ref && pat_ok) begin
                  st   <= ST_DELAY;
                  tcnt <= delay_t;
               end
            end
            ST_DELAY: begin
               if (!m_str) begin
                  st <= ST_IDLE;
               end else if (tcnt == 16'h0000) begin
                  st   <= (dur_t == 16'h0000) ? ST_IDLE : ST_PULSE;
                  tcnt <= dur_t;
               end else if (tick) begin
                  tcnt <= tcnt - 16'h0001;
               end
            end
            ST_PULSE: begin
               if (!m_str || (tick && tcnt == 16'h0001)) begin
                  st <= ST_IDLE;
               end
               if (tick) begin
                  tcnt <= tcnt - 16'h0001;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   // Pad sample and trigger pulse
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_q      <= 1'b0;
         trig_event <= 1'b0;
      end else begin
         pin_q      <= pin_in;
         trig_event <= trig_hit;
      end
   end

   // Pad drive and enable
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_oe <= m_out || m_str || m_pwm;
         if (m_out) begin
            pin_out <= pin_data[`SPG_LEVEL_BIT];
         end else if (m_str) begin
            pin_out <= (st == ST_PULSE) ^ pol;
         end else if (m_pwm) begin
            pin_out <= pwm_high;
         end else begin
            pin_out <= 1'b0;
         end
      end
   end

   // Read data stands one cycle, then returns to zero
   always @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            // Presence bit set in every register except pin timing
            case (reg_addr)
               `SPG_OFF_PAT_CTRL: begin
                  reg_rdata <= {1'b1, 18'h00000, period, 4'h0, count};
               end
               `SPG_OFF_PIN_CTRL: begin
                  reg_rdata <= {1'b1, 11'h000, mode, pin_data[15:1],
                                m_in ? pin_q : pin_data[`SPG_LEVEL_BIT]};
               end
               `SPG_OFF_PIN_TIMING: begin
                  reg_rdata <= timing;
               end
               `SPG_OFF_PAT_MASK: begin
                  reg_rdata <= {1'b1, 15'h0000, mask};
               end
               // Unmapped addresses read as zero
               default: begin
                  reg_rdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

endmodule // spg_gpio_pin
`default_nettype wire

/* tb/spg_props.sv */
// Purpose: Port checks for the GPIO pin block
// Assumes: Pin control shadowed from writes
// Notes:   Three-cycle settle after mode changes
`timescale 1ns/1ps
`default_nettype none
module spg_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        pin_in,
   input wire logic        pin_out,
   input wire logic        pin_oe,
   input wire logic        trig_event
);
   logic [31:0] ctl;
   wire logic [3:0] m = ctl[19:16];
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) ctl <= 32'h0;
      else if (reg_wr && reg_addr == 16'h1110) ctl <= reg_wdata;
   property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_pres; $past(reg_rd) && $past(reg_addr) inside {16'h110c, 16'h1110, 16'h1118} |-> reg_rdata[31];
   endproperty
   a_pres: assert property (p_pres) else $error("presence low");
   property p_resv; $past(reg_rd) && $past(reg_addr) == 16'h110c |-> reg_rdata[30:13] == 18'h0; endproperty
   a_resv: assert property (p_resv) else $error("pattern reserved set");
   property p_off; (m == 4'h0 || m == 4'h2)[*3] |-> !pin_oe; endproperty
   a_off: assert property (p_off) else $error("pin driven in input");
   property p_on; (m inside {4'h1, 4'h3, 4'h4, 4'h8})[*3] |-> pin_oe; endproperty
   a_on: assert property (p_on) else $error("pin not driven");
   property p_lvl; (m == 4'h1 && $stable(ctl))[*3] |-> pin_out == ctl[0]; endproperty
   a_lvl: assert property (p_lvl) else $error("output level wrong");
   property p_rise; (m == 4'h2 && ctl[0])[*3] ##0 $rose(pin_in) |-> ##[1:3] trig_event; endproperty
   a_rise: assert property (p_rise) else $error("rising trigger lost");
   property p_fall; (m == 4'h2 && !ctl[0])[*3] ##0 $fell(pin_in) |-> ##[1:3] trig_event; endproperty
   a_fall: assert property (p_fall) else $error("falling trigger lost");
endmodule // spg_props
bind spg_gpio_pin spg_props u_props (.clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
   .pin_in, .pin_out, .pin_oe, .trig_event);
`default_nettype wire

/* tb/spg_far_end.sv */
// Purpose: Trigger source and strobe lamp
// Assumes: Design drive wins the pad
// Notes:   Counts rising edges while driven
`timescale 1ns/1ps
`default_nettype none
module spg_far_end (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic lvl,
   output wire logic pin_in,
   output var  int   pulses
);
   logic last;
   assign pin_in = pin_oe ? pin_out : lvl;
   always @(posedge clk) begin
      last <= pin_out;
      if (!resetn)
         pulses <= 0;
      else if (pin_oe && pin_out && !last)
         pulses <= pulses + 1;
   end
endmodule // spg_far_end
`default_nettype wire

/* tb/spg_gpio_pin_test.sv */
// Purpose: Register and pin tests of the GPIO pin
// Assumes: Tick every other clock
// Notes:   Strobe reference on integration until the last trigger pass
`timescale 1ns/1ps
`default_nettype none
module spg_gpio_pin_test;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        tick = 1'b0;
   logic        integ_start = 1'b0;
   logic        strobe_ref_trig = 1'b0;
   logic [15:0] reg_addr = 16'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic        lvl = 1'b0;
   wire logic [31:0] reg_rdata;
   wire logic   pin_in, pin_out, pin_oe, trig_event;
   int          pulses, failures = 0, n_tests = 0, cyc = 0, trigs = 0;
   spg_gpio_pin uut (.clk, .resetn, .tick, .integ_start, .strobe_ref_trig, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .pin_in, .pin_out, .pin_oe, .trig_event);
   spg_far_end lamp (.clk, .resetn, .pin_out, .pin_oe, .lvl, .pin_in, .pulses);
   always #20 clk = ~clk;
   always @(posedge clk) begin
      tick <= ~tick;
      cyc++;
      if (trig_event)
         trigs++;
      if (cyc == 3000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", exp, reg_rdata);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(16'h110c, 32'h8000_0100);
      rd(16'h1118, 32'h8000_ffff);
      rd(16'h1114, 32'h0000_0000);
      rd(16'h1200, 32'h0000_0000);
      wr(16'h110c, 32'h0000_030f);
      wr(16'h1118, 32'h0000_2000);
      wr(16'h1114, 32'h0002_0003);
      wr(16'h1110, 32'h0003_0000);
      for (int f = 0; f < 6; f++) begin
         @(posedge clk) integ_start <= 1'b1;
         @(posedge clk) integ_start <= 1'b0;
         repeat (20) @(posedge clk);
         rd(16'h110c, 32'h8000_0300 | 32'((f + 1) % 3));
         chk("strobes", 32'((f + 1) / 3), 32'(pulses));
      end
      wr(16'h1110, 32'h0004_0000);
      repeat (40) @(posedge clk);
      chk("pwm", 32'h6, 32'(pulses));
      wr(16'h1110, 32'h0003_0001);
      repeat (3) @(posedge clk);
      chk("idle", 32'h1, 32'(pin_out));
      wr(16'h1110, 32'h0001_0001);
      rd(16'h1110, 32'h8001_0001);
      wr(16'h1110, 32'h0008_0000);
      rd(16'h1110, 32'h8008_0000);
      @(posedge clk) lvl <= 1'b1;
      wr(16'h1110, 32'h0000_0000);
      repeat (2) @(posedge clk);
      rd(16'h1110, 32'h8000_0001);
      for (int d = 0; d < 2; d++) begin
         strobe_ref_trig <= (d == 1);
         wr(16'h1110, 32'h0002_0000 | 32'(d));
         repeat (4) begin
            repeat (4) @(posedge clk);
            lvl <= ~lvl;
         end
      end
      repeat (3) @(posedge clk);
      chk("trigs", 32'h4, 32'(trigs));
      rd(16'h110c, 32'h8000_0302);
      report_and_stop();
   end
endmodule // spg_gpio_pin_test
`default_nettype wire
